// file: logic/tct_defs.vh
// What this block does
// R1 - Three identical timers, each a 32-bit down counter with a preset period.
// R2 - Counter decrements at clock rate divided by a 16-bit prescale setting.
// R3 - Counter reaching zero emits a one-cycle interrupt pulse.
// R4 - At zero the counter reloads the full 32-bit period and keeps counting.
// R5 - The counter is loaded from the period value to start a countdown.
// R6 - Timer 2 pulse drives CPU interrupt line fourteen directly.
// R7 - Timer 1 pulse is connectable to CPU interrupt line thirteen.
// R8 - Timer 0 pulse feeds the interrupt expander block.
// R9 - All counting and pulses run on the system clock.
// R10 - Processor reads and writes timer registers over its memory bus.
// R11 - Each timer has eight 16-bit words; timers are spaced eight words apart.
// R12 - Prescale counter reloads on underflow; each underflow decrements once.
`ifndef TCT_DEFS_VH
`define TCT_DEFS_VH

// ----------------------------------------------------------------------
// Address map, 16-bit word addresses
// ----------------------------------------------------------------------
`define TCT_BASE_ADDR     16'h0c00
`define TCT_STRIDE_LOG2   3
`define TCT_SPAN_LOG2     5
`define TCT_OFS_CNT_LO    3'h0
`define TCT_OFS_CNT_HI    3'h1
`define TCT_OFS_RLD_LO    3'h2
`define TCT_OFS_RLD_HI    3'h3
`define TCT_OFS_CTRL      3'h4
`define TCT_OFS_RSVD      3'h5
`define TCT_OFS_PSC_LO    3'h6
`define TCT_OFS_PSC_HI    3'h7

// ----------------------------------------------------------------------
// Control word fields and reset values
// ----------------------------------------------------------------------
`define TCT_CTRL_STOP     4
`define TCT_CTRL_RELOAD   5
`define TCT_CTRL_FLAG     15
`define TCT_RST_COUNT     32'hffffffff
`define TCT_RST_PERIOD    32'hffffffff
`define TCT_RST_PSC       16'h0000
`define TCT_ZERO32        32'h00000000
`define TCT_ZERO16        16'h0000
`define TCT_ONE32         32'h00000001
`define TCT_ONE16         16'h0001

`endif

// file: logic/tct_timer_unit.v
`timescale 1ns/100ps
`default_nettype none
`include "tct_defs.vh"

module tct_timer_unit #(
  parameter CW = 32,
  parameter PW = 16
) (
  // Clock and reset
  input  wire          clk,
  input  wire          reset,
  // Register access from the decoder
  input  wire          wrEn,
  input  wire          rdEn,
  input  wire [2:0]    wordSel,
  input  wire [15:0]   wrData,
  output reg  [15:0]   rdData,
  // Event
  output reg           tickIrq
);

  reg  [CW-1:0] countFf;
  reg  [CW-1:0] reloadFf;
  reg  [PW-1:0] pscSetFf;
  reg  [PW-1:0] pscCntFf;
  reg           stopFf;
  reg           flagFf;
  reg  [15:0]   nxt_rdData;

  wire wrCnt = wrEn && (wordSel == `TCT_OFS_CNT_LO || wordSel == `TCT_OFS_CNT_HI);
  wire wrCtl = wrEn && (wordSel == `TCT_OFS_CTRL);
  wire doLoad = wrCtl && wrData[`TCT_CTRL_RELOAD];
  // Prescale underflow: when the prescale count is zero one decrement is due
  wire pscTick = !stopFf && (pscCntFf == `TCT_ZERO16); // see R12
  wire atZero = pscTick && (countFf == `TCT_ZERO32);

  // ----------------------------------------------------------------------
  // Counting, all on the system clock
  // ----------------------------------------------------------------------
  always @(posedge clk or posedge reset) // see R9
  begin
    if (reset)
    begin
      countFf  <= `TCT_RST_COUNT;
      reloadFf <= `TCT_RST_PERIOD;
      pscSetFf <= `TCT_RST_PSC;
      pscCntFf <= `TCT_RST_PSC;
      stopFf   <= 1'b0;
      flagFf   <= 1'b0;
      tickIrq  <= 1'b0;
      rdData   <= `TCT_ZERO16;
    end
    else
    begin
      rdData  <= nxt_rdData;
      tickIrq <= atZero; // see R3
      if (wrEn && wordSel == `TCT_OFS_RLD_LO)
        reloadFf[15:0] <= wrData;
      if (wrEn && wordSel == `TCT_OFS_RLD_HI)
        reloadFf[CW-1:16] <= wrData[CW-17:0];
      if (wrEn && wordSel == `TCT_OFS_PSC_LO)
        pscSetFf <= wrData[PW-1:0];
      if (wrCtl)
        stopFf <= wrData[`TCT_CTRL_STOP];
      // Hardware set wins over a write-one-to-clear in the same cycle
      if (atZero)
        flagFf <= 1'b1;
      else if (wrCtl && wrData[`TCT_CTRL_FLAG])
        flagFf <= 1'b0;
      // Prescaler reloads on underflow; 0 or 1 both give one tick per clock
      if (doLoad || pscTick)
        pscCntFf <= (pscSetFf == `TCT_ZERO16) ? `TCT_ZERO16 : pscSetFf - `TCT_ONE16; // see R12
      else if (!stopFf)
        pscCntFf <= pscCntFf - `TCT_ONE16;
      if (doLoad)
        countFf <= reloadFf; // see R5
      else if (wrCnt && wordSel == `TCT_OFS_CNT_LO)
        countFf[15:0] <= wrData;
      else if (wrCnt)
        countFf[CW-1:16] <= wrData[CW-17:0];
      else if (atZero)
        countFf <= reloadFf; // see R4
      else if (pscTick)
        countFf <= countFf - `TCT_ONE32; // see R2
    end
  end

  // ----------------------------------------------------------------------
  // Read mux, registered so read data lands one cycle after the strobe
  // ----------------------------------------------------------------------
  always @*
  begin
    nxt_rdData = 16'h0000;
    if (rdEn)
    begin
      case (wordSel)
        `TCT_OFS_CNT_LO: nxt_rdData = countFf[15:0];
        `TCT_OFS_CNT_HI: nxt_rdData = countFf[CW-1:16];
        `TCT_OFS_RLD_LO: nxt_rdData = reloadFf[15:0];
        `TCT_OFS_RLD_HI: nxt_rdData = reloadFf[CW-1:16];
        `TCT_OFS_CTRL:   nxt_rdData = {flagFf, 10'h000, stopFf, 4'h0};
        `TCT_OFS_PSC_LO: nxt_rdData = pscSetFf;
        `TCT_OFS_PSC_HI: nxt_rdData = pscCntFf;
        default:         nxt_rdData = 16'h0000;
      endcase
    end
  end

endmodule // tct_timer_unit
`default_nettype wire

// file: logic/tct_cpu_timers.v
`timescale 1ns/100ps
`default_nettype none
`include "tct_defs.vh"

module tct_cpu_timers #(
  parameter NUM_TIMERS = 3,
  parameter CW         = 32,
  parameter PW         = 16
) (
  // Clock and reset
  input  wire          clk,
  input  wire          reset,
  // Processor memory bus, 16-bit word addressed
  input  wire [15:0]   busAddr,
  input  wire          busWr,
  input  wire          busRd,
  input  wire [15:0]   busWrData,
  output reg  [15:0]   busRdData,
  // Interrupt outputs
  output wire          irqExpanderTimer0,
  output wire          cpuIrqLineThirteen,
  output wire          cpuIrqLineFourteen
);

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  // Timers sit in one window above the base; anything else is not ours
  localparam [15:0] BASE_WORD = `TCT_BASE_ADDR;

  function hitsTimer;
    input [15:0] addr;
    input integer idx;
    begin
      hitsTimer = (addr[15:`TCT_SPAN_LOG2] == BASE_WORD[15:`TCT_SPAN_LOG2])
                  && (addr[`TCT_SPAN_LOG2-1:`TCT_STRIDE_LOG2] == idx[1:0]); // see R11
    end
  endfunction

  wire [NUM_TIMERS-1:0] tickIrq;
  wire [15:0]           unitRd [0:NUM_TIMERS-1];

  genvar g;
  generate
    for (g = 0; g < NUM_TIMERS; g = g + 1)
    begin : gTimer
      // Identical units, one per timer
      tct_timer_unit #(
        .CW (CW),
        .PW (PW)
      ) uUnit ( // see R1
        .clk     (clk),
        .reset   (reset),
        .wrEn    (busWr && hitsTimer(busAddr, g)), // see R10
        .rdEn    (busRd && hitsTimer(busAddr, g)), // see R10
        .wordSel (busAddr[`TCT_STRIDE_LOG2-1:0]),
        .wrData  (busWrData),
        .rdData  (unitRd[g]),
        .tickIrq (tickIrq[g])
      );
    end
  endgenerate

  // Units return zero when not selected, so an OR merges them
  integer i;
  always @*
  begin
    busRdData = 16'h0000;
    for (i = 0; i < NUM_TIMERS; i = i + 1)
      busRdData = busRdData | unitRd[i];
  end

  // ----------------------------------------------------------------------
  // Interrupt routing
  // ----------------------------------------------------------------------
  assign irqExpanderTimer0  = tickIrq[0]; // see R8
  assign cpuIrqLineThirteen = tickIrq[1]; // see R7
  assign cpuIrqLineFourteen = tickIrq[2]; // see R6

endmodule // tct_cpu_timers
`default_nettype wire

// file: testbench/tct_timer_checker.sv
`timescale 1ns/100ps
`default_nettype none
module tct_timer_checker (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // Bus
  input wire logic [15:0] busAddr,
  input wire logic        busWr,
  input wire logic        busRd,
  input wire logic [15:0] busWrData,
  input wire logic [15:0] busRdData,
  // Interrupts
  input wire logic        irqExpanderTimer0,
  input wire logic        cpuIrqLineThirteen,
  input wire logic        cpuIrqLineFourteen
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_idle_rd_zero: assert property (!busRd |=> busRdData == 16'h0000)
    else $error("read data not zero without read");
  a_unmapped_rd_zero: assert property (busRd && (busAddr < 16'h0c00 || busAddr > 16'h0c17)
    |=> busRdData == 16'h0000) else $error("unmapped read not zero");
  a_rsvd_rd_zero: assert property (busRd && busAddr[15:3] == 13'h0180 && busAddr[2:0] == 3'h5
    |=> busRdData == 16'h0000) else $error("reserved read not zero");
  a_reload_bit_zero: assert property (busRd && busAddr == 16'h0c14 |=> !busRdData[5])
    else $error("reload bit reads one");
  a_period_readback: assert property (busWr && busAddr == 16'h0c12 ##1 busRd && busAddr == 16'h0c12
    |=> busRdData == $past(busWrData, 2)) else $error("period readback wrong");
  a_irq0_one_cycle: assert property ($rose(irqExpanderTimer0) |=> !irqExpanderTimer0)
    else $error("timer0 pulse too long");
  a_irq1_one_cycle: assert property ($rose(cpuIrqLineThirteen) |=> !cpuIrqLineThirteen)
    else $error("timer1 pulse too long");
  a_irq2_one_cycle: assert property ($rose(cpuIrqLineFourteen) |=> !cpuIrqLineFourteen)
    else $error("timer2 pulse too long");
endmodule // tct_timer_checker
bind tct_cpu_timers tct_timer_checker chk_u (.clk(clk), .reset(reset), .busAddr(busAddr),
  .busWr(busWr), .busRd(busRd), .busWrData(busWrData), .busRdData(busRdData),
  .irqExpanderTimer0(irqExpanderTimer0), .cpuIrqLineThirteen(cpuIrqLineThirteen),
  .cpuIrqLineFourteen(cpuIrqLineFourteen));
`default_nettype wire

// file: testbench/tct_irq_sink.sv
`timescale 1ns/100ps
`default_nettype none
module tct_irq_sink (
  // Clock
  input wire logic       clk,
  // Interrupt lines, one per timer
  input wire logic [2:0] irqIn
);
  // Gap between the two latest pulses, so startup phase does not matter
  int now = 0;
  int last[3] = '{0, 0, 0};
  int gap[3] = '{0, 0, 0};
  int cnt[3] = '{0, 0, 0};
  always @(posedge clk)
  begin
    now <= now + 1;
    for (int i = 0; i < 3; i++)
      if (irqIn[i] === 1'b1)
      begin
        gap[i] <= now - last[i];
        last[i] <= now;
        cnt[i] <= cnt[i] + 1;
      end
  end
endmodule // tct_irq_sink
`default_nettype wire

// file: testbench/triple_cpu_timer_bench.sv
`timescale 1ns/100ps
`default_nettype none
module triple_cpu_timer_bench;
  logic        clk = 0, reset = 1, busWr = 0, busRd = 0;
  logic [15:0] busAddr = 16'h0000, busWrData = 16'h0000, got;
  wire  [15:0] busRdData;
  wire         irq0, irq1, irq2;
  int          n_mismatch = 0, checks_done = 0;
  tct_cpu_timers dut_u (.clk(clk), .reset(reset), .busAddr(busAddr), .busWr(busWr),
    .busRd(busRd), .busWrData(busWrData), .busRdData(busRdData), .irqExpanderTimer0(irq0),
    .cpuIrqLineThirteen(irq1), .cpuIrqLineFourteen(irq2));
  tct_irq_sink sink_u (.clk(clk), .irqIn({irq2, irq1, irq0}));
  initial forever #5 clk = ~clk;
  task automatic wrap_up;
    if (n_mismatch == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(string what, logic [31:0] exp, logic [31:0] seen);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Strobe stays up between back-to-back calls; idle lowers it
  task automatic wr(logic [15:0] a, logic [15:0] d);
    busRd = 0;
    busAddr = a;
    busWrData = d;
    busWr = 1;
    @(negedge clk);
  endtask
  task automatic rd(logic [15:0] a);
    busWr = 0;
    busAddr = a;
    busRd = 1;
    @(negedge clk);
    got = busRdData;
  endtask
  task automatic idle;
    busWr = 0;
    busRd = 0;
    @(negedge clk);
  endtask
  task automatic chk_ctrl;
    wr(16'h0c04, 16'h0010);
    rd(16'h0c04);
    cmp("ctrl flag stop", 32'h00008010, got);
    wr(16'h0c04, 16'h8010);
    rd(16'h0c04);
    cmp("ctrl cleared", 32'h00000010, got);
    wr(16'h0c00, 16'h1234);
    wr(16'h0c01, 16'h0001);
    rd(16'h0c00);
    cmp("count lo wr", 32'h00001234, got);
    rd(16'h0c01);
    cmp("count hi wr", 32'h00000001, got);
    idle();
    idle();
    idle();
    rd(16'h0c00);
    cmp("count stopped", 32'h00001234, got);
    wr(16'h0c04, 16'h0000);
    rd(16'h0c00);
    cmp("count run 0", 32'h00001234, got);
    rd(16'h0c00);
    cmp("count run 1", 32'h00001233, got);
    rd(16'h0c04);
    cmp("ctrl running", 32'h00000000, got);
    idle();
  endtask
  task automatic chk_mid_reset;
    idle();
    reset = 1;
    repeat (2) @(negedge clk);
    reset = 0;
    chk_reset();
    idle();
  endtask
  task automatic chk_reset;
    for (int n = 0; n < 3; n++)
    begin
      rd(16'h0c03 + 16'(n * 8));
      cmp("period hi", 32'h0000ffff, got);
      rd(16'h0c06 + 16'(n * 8));
      cmp("prescale", 32'h00000000, got);
    end
    rd(16'h0c18);
    cmp("unmapped", 32'h00000000, got);
    rd(16'h0c05);
    cmp("reserved", 32'h00000000, got);
  endtask
  task automatic chk_load;
    wr(16'h0c13, 16'h0000);
    wr(16'h0c12, 16'h0030);
    rd(16'h0c12);
    cmp("period lo", 32'h00000030, got);
    wr(16'h0c14, 16'h0030);
    rd(16'h0c10);
    cmp("count lo", 32'h00000030, got);
    rd(16'h0c11);
    cmp("count hi", 32'h00000000, got);
  endtask
  task automatic chk_rate;
    logic [15:0] per[3] = '{16'h0004, 16'h0003, 16'h0002};
    logic [15:0] psc[3] = '{16'h0001, 16'h0002, 16'h0000};
    logic [31:0] gaps[3] = '{32'h5, 32'h8, 32'h3};
    int k;
    for (int n = 0; n < 3; n++)
    begin
      wr(16'h0c03 + 16'(n * 8), 16'h0000);
      wr(16'h0c02 + 16'(n * 8), per[n]);
      wr(16'h0c06 + 16'(n * 8), psc[n]);
      wr(16'h0c04 + 16'(n * 8), 16'h0020);
    end
    idle();
    for (int n = 0; n < 3; n++)
    begin
      k = 0;
      while (sink_u.cnt[n] < 3 && k < 200)
      begin
        @(negedge clk);
        k++;
      end
      if (k == 200)
      begin
        n_mismatch++;
        wrap_up();
      end
      cmp("irq gap", gaps[n], sink_u.gap[n]);
    end
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    reset = 0;
    chk_reset();
    chk_load();
    chk_rate();
    chk_ctrl();
    chk_mid_reset();
    wrap_up();
  end
endmodule // triple_cpu_timer_bench
`default_nettype wire
